// [core/pdsc_top.sv]
`timescale 1ns/1ps
module pdsc_top #(
  parameter int unsigned STROKE_CYC = pdsc_pkg::STROKE_CYC, // cycles per stroke at 100 %
  parameter int unsigned BANNER_CYC = pdsc_pkg::BANNER_CYC, // banner length in cycles
  parameter logic [15:0] STORE_MAX  = pdsc_pkg::STORE_MAX   // pending pulse ceiling
) (
  input  wire logic                 clk,             // 20 MHz
  input  wire logic                 nrst,            // sync reset, active low
  input  wire logic                 ce,              // clock enable
  input  wire logic                 flow_pulse,      // flow meter pin
  input  wire logic                 level_probe,     // level monitor pin
  input  wire logic                 over_temp,       // temperature pin
  input  wire logic                 fault_err,       // hardware fault pin, first code
  input  wire logic                 fault_fail,      // hardware fault pin, second code
  input  wire logic                 key_start_stop,  // start/stop key pin
  input  wire logic                 key_both_arrows, // both arrow keys held pin
  input  wire logic                 save_settings,   // leave programming, one cycle
  input  pdsc_pkg::pdsc_mode_t      mode_in,         // mode to save
  input  wire logic [15:0]          n_in,            // n to save
  input  wire logic                 store_en_in,     // store enable to save
  input  wire logic                 set_pct,         // percent adjust, one cycle
  input  wire logic [6:0]           pct_in,          // percent 1..100
  output logic                      stroke,          // one-cycle stroke pulse
  output logic                      pump_run,        // pump running
  output logic                      stop_icon,       // stop indicator
  output logic                      level_icon,      // level indicator
  output logic                      temp_notice,     // temperature notice
  output logic [1:0]                fault_code,      // latched fault code
  output logic                      alarm_led,       // alarm LED
  output logic                      store_blink,     // store indicator blink request
  output logic                      overflow_alarm,  // store overflow
  output logic                      pulses_dropped_notice, // lost-pulse notice
  output logic                      settings_saved_banner, // saved banner
  output logic                      show_percent     // percent shown
);
  function automatic logic is_prop(input pdsc_pkg::pdsc_mode_t m);
    is_prop = (m != pdsc_pkg::MODE_CONST);
  endfunction : is_prop

  pdsc_if b ();

  pdsc_stroke_timer #(
    .STROKE_CYC (STROKE_CYC)
  ) u_timer (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .t    (b.timer)
  );

  pdsc_pulse_store #(
    .STORE_MAX (STORE_MAX)
  ) u_store (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .s    (b.store)
  );

  // pin synchronisers; third stage only feeds the edge detect
  logic [pdsc_pkg::NPIN-1:0] pin_raw;
  logic [pdsc_pkg::NPIN-1:0] lvl;
  logic [pdsc_pkg::NPIN-1:0] rise;

  assign pin_raw = {key_both_arrows, key_start_stop, fault_fail, fault_err,
                    over_temp, level_probe, flow_pulse};

  genvar gi;
  generate
    for (gi = 0; gi < pdsc_pkg::NPIN; gi++) begin : g_sync
      logic m_q;
      logic l_q;
      logic d_q;
      always_ff @(posedge clk) begin
        if (!nrst) begin
          m_q <= 1'b0;
          l_q <= 1'b0;
          d_q <= 1'b0;
        end else if (ce) begin
          m_q <= pin_raw[gi];
          l_q <= m_q;
          d_q <= l_q;
        end
      end
      assign lvl[gi]  = l_q;
      assign rise[gi] = l_q & ~d_q;
    end
  endgenerate

  logic level;
  logic temp;
  logic fault_any;
  logic ss_rise;

  assign level     = lvl[pdsc_pkg::PIN_LEVEL];
  assign temp      = lvl[pdsc_pkg::PIN_TEMP];
  assign fault_any = lvl[pdsc_pkg::PIN_ERR] | lvl[pdsc_pkg::PIN_FAIL];
  assign ss_rise   = rise[pdsc_pkg::PIN_SS];

  // settings
  pdsc_pkg::pdsc_mode_t mode_q;
  logic [15:0]          n_q;
  logic [6:0]           pct_q;
  logic                 store_en_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_q     <= pdsc_pkg::MODE_DEF;
      pct_q      <= pdsc_pkg::PCT_DEF;
      n_q        <= pdsc_pkg::N_DEF;
      store_en_q <= pdsc_pkg::STORE_DEF;
    end else if (ce) begin
      if (save_settings) begin
        mode_q     <= mode_in;
        n_q        <= n_in;
        store_en_q <= store_en_in;
        // proportional modes start from full scale
        pct_q      <= is_prop(mode_in) ? pdsc_pkg::PCT_FULL : pct_q;
      end else if (set_pct) begin
        pct_q      <= pct_in;
      end
    end
  end

  // saved banner, then the percentage
  logic [31:0] ban_q;
  logic        banner_q;
  logic        show_pct_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ban_q <= '0;
    end else if (ce) begin
      if (save_settings) begin
        ban_q <= 32'(BANNER_CYC);
      end else if (ban_q != 32'h0000_0000) begin
        ban_q <= ban_q - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      banner_q   <= 1'b0;
      show_pct_q <= 1'b1;
    end else if (ce) begin
      if (save_settings) begin
        banner_q   <= 1'b1;
        show_pct_q <= 1'b0;
      end else if (ban_q == 32'h0000_0001) begin
        banner_q   <= 1'b0;
        show_pct_q <= 1'b1;
      end
    end
  end

  // pump run state
  pdsc_pkg::pdsc_pump_t pump_q;
  logic [1:0]           fcode_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pump_q <= pdsc_pkg::PS_STOP;
    end else if (ce) begin
      unique case (pump_q)
        pdsc_pkg::PS_STOP: begin
          if (fault_any) begin
            pump_q <= pdsc_pkg::PS_FAULT;
          end else if (ss_rise && !level && !temp) begin
            pump_q <= pdsc_pkg::PS_RUN;
          end
        end
        pdsc_pkg::PS_RUN: begin
          if (fault_any) begin
            pump_q <= pdsc_pkg::PS_FAULT;
          end else if (level || temp || ss_rise) begin
            pump_q <= pdsc_pkg::PS_STOP;
          end
        end
        // no way out but reset
        pdsc_pkg::PS_FAULT: pump_q <= pdsc_pkg::PS_FAULT;
        default:            pump_q <= pdsc_pkg::PS_STOP;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fcode_q <= pdsc_pkg::FAULT_NONE;
    end else if (ce && fault_any && pump_q != pdsc_pkg::PS_FAULT) begin
      fcode_q <= lvl[pdsc_pkg::PIN_ERR] ? pdsc_pkg::FAULT_ERR : pdsc_pkg::FAULT_FAIL;
    end
  end

  // pulse engine
  logic              run;
  logic              prop;
  logic              flow_rise;
  logic              busy;
  logic              direct;
  logic              late;
  logic              take;
  logic              fire_prop;
  logic              susp_q;
  logic [15:0]       owed_q;
  logic [23:0]       acc_q;
  logic [23:0]       thr;
  logic [23:0]       sum;

  assign run       = (pump_q == pdsc_pkg::PS_RUN);
  assign prop      = is_prop(mode_q);
  assign flow_rise = rise[pdsc_pkg::PIN_FLOW] & prop;
  assign busy      = (owed_q != 16'h0000);
  // a pulse is served at once only with nothing owed and nothing queued
  assign direct    = flow_rise & ~busy & b.empty;
  assign late      = flow_rise & ~direct;
  assign b.push    = late & store_en_q;
  assign b.pop     = ~busy & ~b.empty & ~susp_q & ~flow_rise;
  assign take      = direct | b.pop;
  assign thr       = 24'(n_q * 23'(pdsc_pkg::PCT_FULL));
  assign sum       = acc_q + 24'(pct_q);
  assign fire_prop = run & prop & busy & b.ready;
  assign b.step    = prop ? pdsc_pkg::PCT_FULL : pct_q;
  assign b.fire    = prop ? fire_prop : (run & b.ready);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      owed_q <= '0;
    end else if (ce) begin
      if (save_settings) begin
        owed_q <= '0;
      end else if (take) begin
        if (mode_q == pdsc_pkg::MODE_MUL_N) begin
          owed_q <= n_q;
        end else if (sum >= thr) begin
          owed_q <= 16'h0001;
        end
      end else if (fire_prop) begin
        owed_q <= owed_q - 16'h0001;
      end
    end
  end

  // each pulse adds the percentage; n*100 of it makes a stroke
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc_q <= '0;
    end else if (ce) begin
      if (save_settings) begin
        acc_q <= '0;
      end else if (take && mode_q == pdsc_pkg::MODE_DIV_N) begin
        acc_q <= (sum >= thr) ? sum - thr : sum;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      susp_q <= 1'b0;
    end else if (ce) begin
      if (rise[pdsc_pkg::PIN_ARROWS]) begin
        susp_q <= 1'b1;
      end else if (flow_rise) begin
        susp_q <= 1'b0;
      end
    end
  end

  // notices and alarm
  logic stroke_q;
  logic dropped_q;
  logic ovf_q;
  logic blink_q;
  logic alarm_q;
  logic level_q;
  logic temp_q;
  logic run_q;
  logic stop_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dropped_q <= 1'b0;
    end else if (ce) begin
      if (late && !store_en_q) begin
        dropped_q <= 1'b1;
      end else if (save_settings) begin
        dropped_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ovf_q <= 1'b0;
    end else if (ce) begin
      if (b.push && b.full) begin
        ovf_q <= 1'b1;
      end else if (!b.full) begin
        ovf_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      stroke_q <= 1'b0;
      blink_q  <= 1'b0;
      alarm_q  <= 1'b0;
      level_q  <= 1'b0;
      temp_q   <= 1'b0;
      run_q    <= 1'b0;
      stop_q   <= 1'b1;
    end else if (ce) begin
      stroke_q <= b.fire;
      // keeps blinking until the stroke of the last stored pulse is done
      blink_q  <= ~b.empty | (busy & blink_q);
      run_q    <= run;
      stop_q   <= ~run;
      level_q  <= level;
      temp_q   <= temp;
      alarm_q  <= level | temp | ovf_q | (pump_q == pdsc_pkg::PS_FAULT);
    end
  end

  assign stroke                = stroke_q;
  assign pump_run              = run_q;
  assign stop_icon             = stop_q;
  assign level_icon            = level_q;
  assign temp_notice           = temp_q;
  assign fault_code            = fcode_q;
  assign alarm_led             = alarm_q;
  assign store_blink           = blink_q;
  assign overflow_alarm        = ovf_q;
  assign pulses_dropped_notice = dropped_q;
  assign settings_saved_banner = banner_q;
  assign show_percent          = show_pct_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_div_one;
    (ce && !save_settings && take && mode_q == pdsc_pkg::MODE_DIV_N && sum >= thr)
      |=> owed_q == 16'h0001;
  endproperty
  a_div_one: assert property (p_div_one) else $error("n:1 stroke not owed");

  property p_store_sat;
    (ce && b.full && b.push) |=> b.count == STORE_MAX;
  endproperty
  a_store_sat: assert property (p_store_sat) else $error("store wrapped");

  property p_drain;
    (ce && b.pop) |=> b.count == $past(b.count) - 16'h0001;
  endproperty
  a_drain: assert property (p_drain) else $error("store pop lost");

  property p_drop;
    (ce && late && !store_en_q) |=> dropped_q;
  endproperty
  a_drop: assert property (p_drop) else $error("lost pulse not flagged");

  property p_blink;
    (ce && !b.empty) |=> blink_q;
  endproperty
  a_blink: assert property (p_blink) else $error("store indicator off");

  property p_ovf;
    (ce && b.push && b.full) |=> ovf_q && b.full;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not raised");

  property p_ovf_off;
    (ce && !b.full) |=> !ovf_q;
  endproperty
  a_ovf_off: assert property (p_ovf_off) else $error("overflow stuck");

  property p_susp;
    (ce && susp_q && !flow_rise) |=> b.count == $past(b.count);
  endproperty
  a_susp: assert property (p_susp) else $error("drain while suspended");

  property p_level;
    (ce && level) |=> pump_q != pdsc_pkg::PS_RUN;
  endproperty
  a_level: assert property (p_level) else $error("pump runs on low level");

  property p_fault;
    (pump_q == pdsc_pkg::PS_FAULT) |=> pump_q == pdsc_pkg::PS_FAULT;
  endproperty
  a_fault: assert property (p_fault) else $error("fault recovered");

  property p_start;
    (ce && pump_q == pdsc_pkg::PS_STOP && ss_rise && !fault_any && !level && !temp)
      |=> pump_q == pdsc_pkg::PS_RUN;
  endproperty
  a_start: assert property (p_start) else $error("start key ignored");
endmodule : pdsc_top

// [core/pdsc_pkg.sv]
package pdsc_pkg;
  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned FULL_SPH   = 24000;              // strokes per hour at 100 %
  localparam int unsigned FULL_SPM   = FULL_SPH / 60;      // 400 per minute
  localparam int unsigned STROKE_CYC = CLK_HZ / FULL_SPM * 60;
  localparam int unsigned BANNER_MS  = 1000;
  localparam int unsigned BANNER_CYC = CLK_HZ / 1000 * BANNER_MS;
  localparam int unsigned PCT_W      = 7;
  localparam int unsigned CNT_W      = 16;
  localparam int unsigned TACC_W     = 32;
  localparam int unsigned PACC_W     = 24;
  localparam logic [6:0]  PCT_FULL   = 7'h64;
  localparam logic [6:0]  PCT_DEF    = 7'h4B;
  localparam logic [15:0] STORE_MAX  = 16'hFFFF;
  localparam logic [15:0] N_DEF      = 16'h0001;
  localparam logic        STORE_DEF  = 1'b0;
  localparam int unsigned PIN_FLOW   = 0;
  localparam int unsigned PIN_LEVEL  = 1;
  localparam int unsigned PIN_TEMP   = 2;
  localparam int unsigned PIN_ERR    = 3;
  localparam int unsigned PIN_FAIL   = 4;
  localparam int unsigned PIN_SS     = 5;
  localparam int unsigned PIN_ARROWS = 6;
  localparam int unsigned NPIN       = 7;
  localparam logic [1:0]  FAULT_NONE = 2'h0;
  localparam logic [1:0]  FAULT_ERR  = 2'h1;
  localparam logic [1:0]  FAULT_FAIL = 2'h2;

  typedef enum logic [1:0] {
    MODE_CONST = 2'h0,
    MODE_DIV_N = 2'h1,
    MODE_MUL_N = 2'h2
  } pdsc_mode_t;

  typedef enum logic [2:0] {
    PS_STOP  = 3'h1,
    PS_RUN   = 3'h2,
    PS_FAULT = 3'h4
  } pdsc_pump_t;

  localparam pdsc_mode_t MODE_DEF = MODE_CONST;
endpackage : pdsc_pkg

// [core/pdsc_if.sv]
`timescale 1ns/1ps
interface pdsc_if;
  logic [6:0]  step;  // rate weight per cycle
  logic        fire;  // stroke issued
  logic        ready; // stroke spacing elapsed
  logic        push;  // pulse into store
  logic        pop;   // pulse out of store
  logic [15:0] count; // pending pulses
  logic        full;
  logic        empty;
  modport timer (input step, input fire, output ready);
  modport store (input push, input pop, output count, output full, output empty);
endinterface : pdsc_if

// [core/pdsc_stroke_timer.sv]
`timescale 1ns/1ps
module pdsc_stroke_timer #(
  parameter int unsigned STROKE_CYC = pdsc_pkg::STROKE_CYC // cycles per stroke at 100 %
) (
  input  wire logic clk,  // system clock
  input  wire logic nrst, // sync reset, active low
  input  wire logic ce,   // clock enable
  pdsc_if.timer     t     // rate port
);
  localparam logic [31:0] LIMIT = 32'(STROKE_CYC * 32'(pdsc_pkg::PCT_FULL));

  logic [31:0] acc_q;

  // weight per cycle is the step (percentage in constant mode, 100 in proportional modes), so spacing scales as 100/step
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc_q <= '0;
    end else if (ce) begin
      if (t.fire) begin
        acc_q <= '0;
      end else if (!t.ready) begin
        acc_q <= acc_q + 32'(t.step);
      end
    end
  end

  assign t.ready = (acc_q >= LIMIT);
endmodule : pdsc_stroke_timer

// [core/pdsc_pulse_store.sv]
`timescale 1ns/1ps
module pdsc_pulse_store #(
  parameter logic [15:0] STORE_MAX = pdsc_pkg::STORE_MAX // pending pulse ceiling
) (
  input  wire logic clk,  // system clock
  input  wire logic nrst, // sync reset, active low
  input  wire logic ce,   // clock enable
  pdsc_if.store     s     // store port
);
  logic [15:0] cnt_q;

  // a push at the ceiling is refused; the count never wraps
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (s.push && !s.pop && !s.full) begin
        cnt_q <= cnt_q + 16'h0001;
      end else if (s.pop && !s.push && !s.empty) begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end

  assign s.count = cnt_q;
  assign s.full  = (cnt_q == STORE_MAX);
  assign s.empty = (cnt_q == 16'h0000);
endmodule : pdsc_pulse_store

// [testbench/pdsc_meter_model.sv]
`timescale 1ns/1ps
module pdsc_meter_model (
  input  wire logic        clk,         // bench clock
  input  wire logic        go,          // start a pulse train
  input  wire logic [15:0] count,       // pulses in the train
  input  wire logic [7:0]  period,      // cycles per pulse, at least 4
  input  wire logic        level_req,   // low liquid wanted
  output logic             flow_pulse,  // meter pulse output
  output logic             level_probe, // probe output
  output logic             busy         // train in progress
);
  logic [15:0] left_q;
  logic [7:0]  ph_q;
  initial begin
    left_q      = 16'h0000;
    ph_q        = 8'h00;
    flow_pulse  = 1'b0;
    level_probe = 1'b0;
  end
  assign busy = (left_q != 16'h0000);
  // two cycles high, rest low: never closer than the synchroniser can resolve
  always @(posedge clk) begin
    level_probe <= level_req;
    if (go) begin
      left_q <= count;
      ph_q   <= 8'h00;
    end else if (busy) begin
      ph_q       <= (ph_q == period - 8'h01) ? 8'h00 : ph_q + 8'h01;
      flow_pulse <= (ph_q < 8'h02);
      if (ph_q == period - 8'h01) begin
        left_q <= left_q - 16'h0001;
      end
    end else begin
      flow_pulse <= 1'b0;
    end
  end
endmodule : pdsc_meter_model

// [testbench/test_proportional_dose_stroke_ctrl.sv]
`timescale 1ns/1ps
module test_proportional_dose_stroke_ctrl;
  localparam int unsigned SC = 20;
  localparam int unsigned BC = 10;
  logic                 clk, nrst, over_temp, fault_err, fault_fail, k_ss, k_ar;
  logic                 save_settings, set_pct, store_en_in, go, level_req;
  pdsc_pkg::pdsc_mode_t mode_in;
  logic [15:0]          n_in, cnt_in;
  logic [7:0]           per_in;
  logic [6:0]           pct_in;
  logic                 flow, level, busy, stroke, pump_run, stop_icon, level_icon;
  logic                 temp_notice, alarm_led, store_blink, overflow_alarm;
  logic                 dropped, banner, show_percent;
  logic [1:0]           fault_code;
  logic [31:0]          error_cnt, n_tests, stroke_cnt, cyc, c0;

  pdsc_top #(.STROKE_CYC(SC), .BANNER_CYC(BC), .STORE_MAX(16'h000C)) dut_u (
    .clk(clk), .nrst(nrst), .ce(1'b1), .flow_pulse(flow), .level_probe(level),
    .over_temp(over_temp), .fault_err(fault_err), .fault_fail(fault_fail),
    .key_start_stop(k_ss), .key_both_arrows(k_ar), .save_settings(save_settings),
    .mode_in(mode_in), .n_in(n_in), .store_en_in(store_en_in), .set_pct(set_pct),
    .pct_in(pct_in), .stroke(stroke), .pump_run(pump_run), .stop_icon(stop_icon),
    .level_icon(level_icon), .temp_notice(temp_notice), .fault_code(fault_code),
    .alarm_led(alarm_led), .store_blink(store_blink), .overflow_alarm(overflow_alarm),
    .pulses_dropped_notice(dropped), .settings_saved_banner(banner),
    .show_percent(show_percent));

  pdsc_meter_model meter_u (.clk(clk), .go(go), .count(cnt_in), .period(per_in),
    .level_req(level_req), .flow_pulse(flow), .level_probe(level), .busy(busy));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wrap_up;
    if (error_cnt == 0 && n_tests != 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (stroke === 1'b1) stroke_cnt <= stroke_cnt + 1;
    if (cyc == 32'd30000) begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  end

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task rst(input int n);
    @(posedge clk);
    nrst <= 1'b0;
    tick(n);
    nrst <= 1'b1;
    tick(3);
  endtask : rst

  // keys are held a few cycles so the synchroniser sees a clean rise
  task key(input bit arrows);
    @(posedge clk);
    if (arrows) k_ar <= 1'b1;
    else k_ss <= 1'b1;
    tick(3);
    k_ar <= 1'b0;
    k_ss <= 1'b0;
    tick(8);
    @(negedge clk);
  endtask : key

  task pct(input logic [6:0] p);
    @(posedge clk);
    pct_in  <= p;
    set_pct <= 1'b1;
    @(posedge clk);
    set_pct <= 1'b0;
  endtask : pct

  task save(input pdsc_pkg::pdsc_mode_t m, input logic [15:0] n, input logic s);
    @(posedge clk);
    mode_in       <= m;
    n_in          <= n;
    store_en_in   <= s;
    save_settings <= 1'b1;
    @(posedge clk);
    save_settings <= 1'b0;
    @(negedge clk);
    chk(banner, 1);
    chk(show_percent, 0);
    tick(BC + 3);
    @(negedge clk);
    chk(banner, 0);
    chk(show_percent, 1);
  endtask : save

  task pulses(input logic [15:0] k, input logic [7:0] p);
    @(posedge clk);
    cnt_in <= k;
    per_in <= p;
    go     <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    repeat (3000) if (busy) @(negedge clk);
    tick(4);
  endtask : pulses

  // tolerance of one stroke for the phase of the window
  task rate(input int n, input int p);
    int e;
    e  = n * p / (SC * 100);
    c0 = stroke_cnt;
    tick(n);
    chk((stroke_cnt - c0 + 1 >= e) && (stroke_cnt - c0 <= e + 1), 1);
  endtask : rate

  task t_defaults;
    @(negedge clk);
    chk(pump_run, 0);
    chk(stop_icon, 1);
    chk(show_percent, 1);
    chk(fault_code, pdsc_pkg::FAULT_NONE);
    key(0);
    chk(pump_run, 1);
    chk(stop_icon, 0);
    rate(400, 75);
    pct(7'h32);
    rate(400, 50);
    pct(7'h64);
    rate(400, 100);
    key(0);
    chk(stop_icon, 1);
    c0 = stroke_cnt;
    tick(100);
    chk(stroke_cnt - c0, 0);
  endtask : t_defaults

  task prop_case(input pdsc_pkg::pdsc_mode_t m, input logic [15:0] n, input logic [6:0] p,
                 input logic [15:0] k, input logic [31:0] e);
    save(m, n, 1'b0);
    if (p != 7'h64) pct(p);
    c0 = stroke_cnt;
    pulses(k, 8'h28);
    tick(80);
    chk(stroke_cnt - c0, e);
    chk(dropped, 0);
  endtask : prop_case

  task t_store;
    save(pdsc_pkg::MODE_DIV_N, 16'h0001, 1'b0);
    pulses(16'h0006, 8'h04);
    tick(150);
    chk(dropped, 1);
    save(pdsc_pkg::MODE_DIV_N, 16'h0001, 1'b0);
    chk(dropped, 0);
    save(pdsc_pkg::MODE_DIV_N, 16'h0001, 1'b1);
    c0 = stroke_cnt;
    pulses(16'h000A, 8'h04);
    @(negedge clk);
    chk(store_blink, 1);
    tick(300);
    @(negedge clk);
    chk(stroke_cnt - c0, 10);
    chk(store_blink, 0);
    chk(overflow_alarm, 0);
    chk(dropped, 0);
    pulses(16'h000A, 8'h04);
    key(1);
    tick(25);
    c0 = stroke_cnt;
    tick(80);
    @(negedge clk);
    chk(stroke_cnt - c0, 0);
    chk(store_blink, 1);
    pulses(16'h0001, 8'h04);
    tick(50);
    chk(stroke_cnt - c0 > 1, 1);
    rst(3);
    @(negedge clk);
    chk(store_blink, 0);
  endtask : t_store

  // pump stopped: one pulse owed, twelve stored, the fourteenth refused
  task t_ovf;
    save(pdsc_pkg::MODE_DIV_N, 16'h0001, 1'b1);
    c0 = stroke_cnt;
    pulses(16'h000E, 8'h04);
    @(negedge clk);
    chk(overflow_alarm, 1);
    chk(alarm_led, 1);
    chk(store_blink, 1);
    key(0);
    chk(pump_run, 1);
    chk(overflow_alarm, 0);
    chk(alarm_led, 0);
    tick(300);
    @(negedge clk);
    chk(stroke_cnt - c0, 13);
    chk(store_blink, 0);
    rst(3);
  endtask : t_ovf

  task t_halt(input bit temp);
    key(0);
    @(posedge clk);
    if (temp) over_temp <= 1'b1;
    else level_req <= 1'b1;
    tick(8);
    @(negedge clk);
    chk(pump_run, 0);
    chk(temp ? temp_notice : level_icon, 1);
    chk(alarm_led, 1);
    key(0);
    chk(pump_run, 0);
    @(posedge clk);
    over_temp <= 1'b0;
    level_req <= 1'b0;
    tick(8);
    @(negedge clk);
    chk(temp ? temp_notice : level_icon, 0);
    chk(alarm_led, 0);
    chk(pump_run, 0);
    key(0);
    chk(pump_run, 1);
    key(0);
  endtask : t_halt

  task t_fault;
    key(0);
    @(posedge clk);
    fault_err <= 1'b1;
    tick(8);
    fault_err <= 1'b0;
    key(0);
    chk(pump_run, 0);
    chk(fault_code, pdsc_pkg::FAULT_ERR);
    chk(alarm_led, 1);
    rst(3);
    fault_fail <= 1'b1;
    tick(8);
    fault_fail <= 1'b0;
    @(negedge clk);
    chk(fault_code, pdsc_pkg::FAULT_FAIL);
    rst(3);
    @(negedge clk);
    chk(fault_code, pdsc_pkg::FAULT_NONE);
  endtask : t_fault

  initial begin
    {nrst, over_temp, fault_err, fault_fail, k_ss, k_ar} = 6'h00;
    {save_settings, set_pct, store_en_in, go, level_req} = 5'h00;
    mode_in    = pdsc_pkg::MODE_CONST;
    n_in       = 16'h0001;
    cnt_in     = 16'h0000;
    per_in     = 8'h04;
    pct_in     = 7'h64;
    error_cnt  = 32'h0;
    n_tests    = 32'h0;
    stroke_cnt = 32'h0;
    cyc        = 32'h0;
    tick(16);
    nrst <= 1'b1;
    tick(3);
    t_defaults;
    key(0);
    prop_case(pdsc_pkg::MODE_DIV_N, 16'h0004, 7'h64, 16'h0008, 2);
    prop_case(pdsc_pkg::MODE_DIV_N, 16'h0004, 7'h50, 16'h0009, 1);
    prop_case(pdsc_pkg::MODE_MUL_N, 16'h0003, 7'h64, 16'h0001, 3);
    t_store;
    t_ovf;
    t_halt(0);
    t_halt(1);
    t_fault;
    wrap_up;
  end
endmodule : test_proportional_dose_stroke_ctrl
